// *** core/msd_pkg.sv ***
// Purpose: constants and types for the move-to status and special register decode block
// Assumes: instruction bit b of the listing is vector bit 31-b (msb first)
// Notes:
package msd_pkg;
  localparam int          ADDR_W       = 8;
  localparam logic [5:0]  OPC_FP       = 6'h3f;
  localparam logic [5:0]  OPC_FX       = 6'h1f;
  localparam logic [9:0]  XO_FLD_IMM   = 10'h086;
  localparam logic [9:0]  XO_BIT_CLR   = 10'h046;
  localparam logic [9:0]  XO_BIT_SET   = 10'h026;
  localparam logic [9:0]  XO_CR_FLD    = 10'h090;
  localparam logic [9:0]  XO_SPR       = 10'h1d3;
  localparam int          OPC_LSB      = 26;
  localparam int          XO_LSB       = 1;
  localparam int          BF_LSB       = 23;
  localparam int          BT_LSB       = 21;
  localparam int          IMM_LSB      = 12;
  localparam int          RC_BIT       = 0;
  localparam int          RS_LSB       = 21;
  localparam int          MASK_LSB     = 12;
  localparam int          SPR_LO_LSB   = 16;
  localparam int          SPR_HI_LSB   = 11;
  localparam int          CR1_LSB      = 24;
  localparam logic [31:0] FP_FIXED     = 32'h6000_0000;
  localparam logic [9:0]  SPR_MQ       = 10'h000;
  localparam logic [9:0]  SPR_XER      = 10'h001;
  localparam logic [9:0]  SPR_LR       = 10'h008;
  localparam logic [9:0]  SPR_CTR      = 10'h009;
  localparam logic [9:0]  SPR_DEC      = 10'h016;
  localparam logic [9:0]  SPR_CLOCK_UPPER_REGISTER     = 10'h014;
  localparam logic [9:0]  SPR_CLOCK_LOWER_REGISTER     = 10'h015;
  localparam logic [7:0]  A_INSTR      = 8'h00;
  localparam logic [7:0]  A_FP_STATUS_CONTROL_REGISTER      = 8'h04;
  localparam logic [7:0]  A_CR         = 8'h08;
  localparam logic [7:0]  A_XER        = 8'h0c;
  localparam logic [7:0]  A_LR         = 8'h10;
  localparam logic [7:0]  A_CTR        = 8'h14;
  localparam logic [7:0]  A_DEC        = 8'h18;
  localparam logic [7:0]  A_MQ         = 8'h1c;
  localparam logic [7:0]  A_CLOCK_UPPER_REGISTER       = 8'h20;
  localparam logic [7:0]  A_CLOCK_LOWER_REGISTER       = 8'h24;
  localparam logic [7:0]  A_CTRL       = 8'h28;
  localparam logic [7:0]  A_IRQ_STS    = 8'h2c;
  localparam logic [7:0]  A_IRQ_MASK   = 8'h30;
  localparam logic [7:0]  A_LAST_SPR   = 8'h34;
  localparam int          A_GPR_BIT    = 7;
  localparam int          CTRL_PRIV    = 0;
  localparam int          CTRL_OLD     = 1;
  localparam int          IRQ_DONE     = 0;
  localparam int          IRQ_PRIV     = 1;
  localparam int          IRQ_ILL      = 2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_XER, SEL_LR, SEL_CTR, SEL_DEC,
    SEL_MQ, SEL_CLOCK_UPPER_REGISTER, SEL_CLOCK_LOWER_REGISTER, SEL_OTHER
  } msd_spr_sel_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } msd_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } msd_axil_rsp_t;

  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              exec_pend;
    logic [31:0]       instr;
    logic [31:0]       fp_status_control_register;
    logic [31:0]       cr;
    logic [31:0]       fixed_point_exception_register;
    logic [31:0]       lr;
    logic [31:0]       ctr;
    logic [31:0]       dec;
    logic [31:0]       mq;
    logic [31:0]       clock_upper_register;
    logic [31:0]       clock_lower_register;
    logic [1:0]        ctrl;
    logic [2:0]        irq_sts;
    logic [2:0]        irq_mask;
    logic [9:0]        last_spr;
    logic [31:0][31:0] gpr;
  } msd_state_t;

  localparam msd_state_t STATE_RST = '0;
endpackage

// *** core/msd_spr_decode.sv ***
// Purpose: classify a special register number
// Assumes: number already has its halves swapped
// Notes: combinational
`timescale 1ns/100ps
`default_nettype none
module msd_spr_decode (
  input  wire logic [9:0]          spr_num,
  input  wire logic                older_variant,
  output var  logic                valid,
  output var  logic                privileged,
  output var  msd_pkg::msd_spr_sel_t sel
);
  always_comb begin
    valid      = 1'b1;
    privileged = 1'b1;
    sel        = msd_pkg::SEL_OTHER;
    case (spr_num)
      msd_pkg::SPR_XER: begin
        privileged = 1'b0;
        sel        = msd_pkg::SEL_XER;
      end
      msd_pkg::SPR_LR: begin
        privileged = 1'b0;
        sel        = msd_pkg::SEL_LR;
      end
      msd_pkg::SPR_CTR: begin
        privileged = 1'b0;
        sel        = msd_pkg::SEL_CTR;
      end
      msd_pkg::SPR_DEC: sel = msd_pkg::SEL_DEC;
      msd_pkg::SPR_MQ: begin
        privileged = 1'b0;
        valid      = older_variant;
        sel        = msd_pkg::SEL_MQ;
      end
      msd_pkg::SPR_CLOCK_UPPER_REGISTER: begin
        valid = older_variant;
        sel   = msd_pkg::SEL_CLOCK_UPPER_REGISTER;
      end
      msd_pkg::SPR_CLOCK_LOWER_REGISTER: begin
        valid = older_variant;
        sel   = msd_pkg::SEL_CLOCK_LOWER_REGISTER;
      end
      10'h012, 10'h013, 10'h019, 10'h01a, 10'h01b,
      10'h110, 10'h111, 10'h112, 10'h113,
      10'h11a, 10'h11c, 10'h11d: sel = msd_pkg::SEL_OTHER;
      default: begin
        // translation pair block 528..543
        if (spr_num[9:4] == 6'h21) begin
          sel = msd_pkg::SEL_OTHER;
        end else begin
          valid = 1'b0;
          sel   = msd_pkg::SEL_NONE;
        end
      end
    endcase
    if (!valid) begin
      sel = msd_pkg::SEL_NONE;
    end
  end
endmodule
`default_nettype wire

// *** core/msd_fp_write.sv ***
// Purpose: next fp status value for field immediate and bit set/clear
// Assumes: fp status bit 0 is vector bit 31
// Notes: combinational; hit marks a recognised fp move
`timescale 1ns/100ps
`default_nettype none
module msd_fp_write (
  input  wire logic [31:0] instr,
  input  wire logic [31:0] fp_status_control_register_q,
  output var  logic        hit,
  output var  logic [31:0] fp_status_control_register_d
);
  logic [5:0]  opc;
  logic [9:0]  xo;
  logic [2:0]  bf;
  logic [4:0]  bt;
  logic [3:0]  imm;
  logic [31:0] m;
  logic [31:0] v;

  assign opc = instr[msd_pkg::OPC_LSB +: 6];
  assign xo  = instr[msd_pkg::XO_LSB +: 10];
  assign bf  = instr[msd_pkg::BF_LSB +: 3];
  assign bt  = instr[msd_pkg::BT_LSB +: 5];
  assign imm = instr[msd_pkg::IMM_LSB +: 4];

  always_comb begin
    hit     = 1'b0;
    m       = 32'h0000_0000;
    v       = 32'h0000_0000;
    fp_status_control_register_d = fp_status_control_register_q;
    if (opc == msd_pkg::OPC_FP) begin
      if (xo == msd_pkg::XO_FLD_IMM) begin
        hit = 1'b1;
        m   = 32'hf000_0000 >> {bf, 2'b00};
        v   = {imm, 28'h000_0000} >> {bf, 2'b00};
        // summary bits of field 0 stay under hardware control
        if (bf == 3'h0) begin
          m = m & ~msd_pkg::FP_FIXED;
        end
      end else if (xo == msd_pkg::XO_BIT_CLR || xo == msd_pkg::XO_BIT_SET) begin
        hit = 1'b1;
        m   = (32'h8000_0000 >> bt) & ~msd_pkg::FP_FIXED;
        v   = (xo == msd_pkg::XO_BIT_SET) ? 32'hffff_ffff : 32'h0000_0000;
      end
      fp_status_control_register_d = (fp_status_control_register_q & ~m) | (v & m);
    end
  end
endmodule
`default_nettype wire

// *** core/msd_core.sv ***
// Purpose: executes fp status, condition field and special register moves
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes: writing the instruction register runs it on the next edge
`timescale 1ns/100ps
`default_nettype none
module msd_core (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire msd_pkg::msd_axil_req_t axil_req,
  output var  msd_pkg::msd_axil_rsp_t axil_rsp,
  output var  logic                  irq
);
  msd_pkg::msd_state_t   s_q;
  msd_pkg::msd_state_t   s_d;
  logic                  fp_hit;
  logic [31:0]           fp_new;
  logic [9:0]            spr_num;
  logic                  spr_valid;
  logic                  spr_priv;
  msd_pkg::msd_spr_sel_t spr_sel;
  logic [5:0]            opc;
  logic [9:0]            xo;
  logic [31:0]           src;
  logic [2:0]            irq_set;
  logic [2:0]            irq_clr;
  logic [31:0]           wval;
  logic [31:0]           rval;

  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] != 2'b00) begin
      ok = 1'b0;
    end else if (a[msd_pkg::A_GPR_BIT]) begin
      ok = 1'b1;
    end else begin
      ok = (a <= msd_pkg::A_LAST_SPR);
    end
    return ok;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] read_word(
    input msd_pkg::msd_state_t st,
    input logic [7:0]          a
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a[msd_pkg::A_GPR_BIT]) begin
      r = st.gpr[a[6:2]];
    end else begin
      case (a)
        msd_pkg::A_INSTR:    r = st.instr;
        msd_pkg::A_FP_STATUS_CONTROL_REGISTER:    r = st.fp_status_control_register;
        msd_pkg::A_CR:       r = st.cr;
        msd_pkg::A_XER:      r = st.fixed_point_exception_register;
        msd_pkg::A_LR:       r = st.lr;
        msd_pkg::A_CTR:      r = st.ctr;
        msd_pkg::A_DEC:      r = st.dec;
        msd_pkg::A_MQ:       r = st.mq;
        msd_pkg::A_CLOCK_UPPER_REGISTER:     r = st.clock_upper_register;
        msd_pkg::A_CLOCK_LOWER_REGISTER:     r = st.clock_lower_register;
        msd_pkg::A_CTRL:     r = {30'h0, st.ctrl};
        msd_pkg::A_IRQ_STS:  r = {29'h0, st.irq_sts};
        msd_pkg::A_IRQ_MASK: r = {29'h0, st.irq_mask};
        msd_pkg::A_LAST_SPR: r = {22'h0, st.last_spr};
        default:             r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  // identifier halves swapped: upper encoded half is the low part
  assign spr_num = {s_q.instr[msd_pkg::SPR_HI_LSB +: 5],
                    s_q.instr[msd_pkg::SPR_LO_LSB +: 5]};
  assign opc     = s_q.instr[msd_pkg::OPC_LSB +: 6];
  assign xo      = s_q.instr[msd_pkg::XO_LSB +: 10];
  assign src     = s_q.gpr[s_q.instr[msd_pkg::RS_LSB +: 5]];

  msd_spr_decode u_spr (
    .spr_num       (spr_num),
    .older_variant (s_q.ctrl[msd_pkg::CTRL_OLD]),
    .valid         (spr_valid),
    .privileged    (spr_priv),
    .sel           (spr_sel)
  );

  msd_fp_write u_fp (
    .instr   (s_q.instr),
    .fp_status_control_register_q (s_q.fp_status_control_register),
    .hit     (fp_hit),
    .fp_status_control_register_d (fp_new)
  );

  assign wval = merge(read_word(s_q, s_q.awaddr), s_q.wdata, s_q.wstrb);
  assign rval = read_word(s_q, axil_req.araddr);

  always_comb begin
    s_d     = s_q;
    irq_set = 3'h0;
    irq_clr = 3'h0;

    // write channels are taken independently
    if (axil_req.awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = axil_req.awaddr;
    end
    if (axil_req.wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = axil_req.wdata;
      s_d.wstrb  = axil_req.wstrb;
    end
    if (s_q.bvalid && axil_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = msd_pkg::RESP_OKAY;
      if (!addr_ok(s_q.awaddr)) begin
        s_d.bresp = msd_pkg::RESP_SLVERR;
      end else if (s_q.awaddr[msd_pkg::A_GPR_BIT]) begin
        s_d.gpr[s_q.awaddr[6:2]] = wval;
      end else begin
        case (s_q.awaddr)
          msd_pkg::A_INSTR: begin
            s_d.instr     = wval;
            s_d.exec_pend = 1'b1;
          end
          msd_pkg::A_FP_STATUS_CONTROL_REGISTER:    s_d.fp_status_control_register    = wval;
          msd_pkg::A_CR:       s_d.cr       = wval;
          msd_pkg::A_XER:      s_d.fixed_point_exception_register      = wval;
          msd_pkg::A_LR:       s_d.lr       = wval;
          msd_pkg::A_CTR:      s_d.ctr      = wval;
          msd_pkg::A_DEC:      s_d.dec      = wval;
          msd_pkg::A_MQ:       s_d.mq       = wval;
          msd_pkg::A_CLOCK_UPPER_REGISTER:     s_d.clock_upper_register     = wval;
          msd_pkg::A_CLOCK_LOWER_REGISTER:     s_d.clock_lower_register     = wval;
          msd_pkg::A_CTRL:     s_d.ctrl     = wval[1:0];
          msd_pkg::A_IRQ_STS:  irq_clr      = s_q.wstrb[0] ? s_q.wdata[2:0] : 3'h0;
          msd_pkg::A_IRQ_MASK: s_d.irq_mask = wval[2:0];
          default:             s_d.bresp    = msd_pkg::RESP_OKAY;
        endcase
      end
    end

    // read channel
    if (s_q.rvalid && axil_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axil_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = addr_ok(axil_req.araddr) ? rval : 32'h0000_0000;
      s_d.rresp  = addr_ok(axil_req.araddr) ? msd_pkg::RESP_OKAY : msd_pkg::RESP_SLVERR;
    end

    // execution overrides a bus write to the same register
    if (s_q.exec_pend) begin
      s_d.exec_pend      = 1'b0;
      irq_set[msd_pkg::IRQ_DONE] = 1'b1;
      if (fp_hit) begin
        s_d.fp_status_control_register = fp_new;
        if (s_q.instr[msd_pkg::RC_BIT]) begin
          s_d.cr[msd_pkg::CR1_LSB +: 4] = fp_new[31:28];
        end
      end else if (opc == msd_pkg::OPC_FX && xo == msd_pkg::XO_CR_FLD) begin
        for (int k = 0; k < 8; k++) begin
          if (s_q.instr[msd_pkg::MASK_LSB + 7 - k]) begin
            s_d.cr[28 - 4*k +: 4] = src[28 - 4*k +: 4];
          end
        end
      end else if (opc == msd_pkg::OPC_FX && xo == msd_pkg::XO_SPR) begin
        if (!spr_valid) begin
          irq_set[msd_pkg::IRQ_ILL] = 1'b1;
        end else if (spr_priv && !s_q.ctrl[msd_pkg::CTRL_PRIV]) begin
          irq_set[msd_pkg::IRQ_PRIV] = 1'b1;
        end else begin
          s_d.last_spr = spr_num;
          // the target and last_spr change, condition field 0 untouched
          case (spr_sel)
            msd_pkg::SEL_XER:  s_d.fixed_point_exception_register  = src;
            msd_pkg::SEL_LR:   s_d.lr   = src;
            msd_pkg::SEL_CTR:  s_d.ctr  = src;
            msd_pkg::SEL_DEC:  s_d.dec  = src;
            msd_pkg::SEL_MQ:   s_d.mq   = src;
            msd_pkg::SEL_CLOCK_UPPER_REGISTER: s_d.clock_upper_register = src;
            msd_pkg::SEL_CLOCK_LOWER_REGISTER: s_d.clock_lower_register = src;
            default:           s_d.last_spr = spr_num;
          endcase
        end
      end else begin
        irq_set[msd_pkg::IRQ_ILL] = 1'b1;
      end
    end

    // set beats a same-cycle clear
    s_d.irq_sts = (s_q.irq_sts & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= msd_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    axil_rsp         = '0;
    axil_rsp.awready = !s_q.aw_held;
    axil_rsp.wready  = !s_q.w_held;
    axil_rsp.bvalid  = s_q.bvalid;
    axil_rsp.bresp   = s_q.bresp;
    axil_rsp.arready = !s_q.rvalid;
    axil_rsp.rvalid  = s_q.rvalid;
    axil_rsp.rdata   = s_q.rdata;
    axil_rsp.rresp   = s_q.rresp;
  end

  assign irq = |(s_q.irq_sts & s_q.irq_mask);
endmodule
`default_nettype wire

// *** sim/msd_core_monitor.sv ***
// Purpose: bus handshake checks on the move decode block ports
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind after the module
`timescale 1ns/100ps
`default_nettype none
module msd_core_monitor (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire msd_pkg::msd_axil_req_t axil_req,
  input wire msd_pkg::msd_axil_rsp_t axil_rsp,
  input wire logic                   irq
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (axil_rsp.bvalid && !axil_req.bready |=>
    axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (axil_rsp.rvalid && !axil_req.rready |=>
    axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read answer dropped");
  read_excl_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read address taken while answer pending");
  read_latency_a: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read answer late");
  write_latency_a: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
    && axil_rsp.wready && !axil_rsp.bvalid |-> ##2 axil_rsp.bvalid)
    else $error("write answer late");
  aw_held_a: assert property (axil_req.awvalid && axil_rsp.awready |=> !axil_rsp.awready)
    else $error("address ready while address held");
  w_held_a: assert property (axil_req.wvalid && axil_rsp.wready |=> !axil_rsp.wready)
    else $error("data ready while data held");
  unmapped_read_a: assert property (axil_req.arvalid && axil_rsp.arready
    && axil_req.araddr == 8'h38 |=> axil_rsp.rresp == msd_pkg::RESP_SLVERR
    && axil_rsp.rdata == 32'h0) else $error("unmapped read not refused");
  irq_cause_a: assert property ($changed(irq) |-> axil_rsp.bvalid || $past(axil_rsp.bvalid))
    else $error("interrupt moved without a write");
endmodule

bind msd_core msd_core_monitor u_monitor (
  .aclk     (aclk),
  .aresetn  (aresetn),
  .axil_req (axil_req),
  .axil_rsp (axil_rsp),
  .irq      (irq)
);
`default_nettype wire

// *** sim/msd_core_tb.sv ***
// Purpose: self-checking bench for the move decode block
// Assumes: 25 MHz clock, reset held 10 cycles
// Notes: registers reached through AXI4-Lite master tasks
`timescale 1ns/100ps
`default_nettype none
module msd_core_tb;
  logic                   aclk;
  logic                   aresetn;
  msd_pkg::msd_axil_req_t req;
  msd_pkg::msd_axil_rsp_t rsp;
  logic                   irq;
  int                     n_errors;
  int                     samples_checked;
  logic [31:0]            fp;
  logic [31:0]            cr;
  logic [31:0]            g;
  logic [31:0]            d;
  logic [31:0]            pre;
  logic [1:0]             r;
  logic [2:0]             bf;
  logic [3:0]             imm;
  logic [7:0]             m;
  logic [4:0]             rs;
  logic                   rc;
  logic [9:0]             spn [9];
  logic [7:0]             spa [9];

  msd_core dut (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .axil_req (req),
    .axil_rsp (rsp),
    .irq      (irq)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // readies and answers are sampled settled, 1 ns after an edge, and hold until the edge that acts on them
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] o);
    int   n;
    logic aw_t;
    logic w_t;
    logic b_t;
    n = 0;
    b_t = 1'b0;
    o = 2'h0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      #1;
      aw_t = rsp.awready;
      w_t  = rsp.wready;
      b_t  = rsp.bvalid;
      o    = rsp.bresp;
      @(posedge aclk);
      n++;
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
    end while (b_t !== 1'b1 && n < 100);
    req.bready <= 1'b0;
    if (b_t !== 1'b1) n_errors++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
    int   n;
    logic ar_t;
    logic r_t;
    n = 0;
    r_t = 1'b0;
    v = 32'h0000_0000;
    o = 2'h0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      #1;
      ar_t = rsp.arready;
      r_t  = rsp.rvalid;
      v    = rsp.rdata;
      o    = rsp.rresp;
      @(posedge aclk);
      n++;
      if (ar_t) req.arvalid <= 1'b0;
    end while (r_t !== 1'b1 && n < 100);
    req.rready <= 1'b0;
    if (r_t !== 1'b1) n_errors++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask

  // clear status, run one instruction, compare the events it raised
  task automatic exec(input logic [31:0] ins, input logic [2:0] sts);
    wr(msd_pkg::A_IRQ_STS, 32'h0000_0007, r);
    wr(msd_pkg::A_INSTR, ins, r);
    rdc(msd_pkg::A_IRQ_STS, {29'h0, sts});
  endtask

  function automatic logic [31:0] f_fld(input logic [31:0] o, input logic [2:0] f,
                                        input logic [3:0] v);
    logic [31:0] n;
    n = o;
    n[31-4*f -: 4] = v;
    n[30:29] = o[30:29];
    return n;
  endfunction

  function automatic logic [31:0] f_crm(input logic [31:0] o, input logic [31:0] s,
                                        input logic [7:0] k);
    logic [31:0] n;
    n = o;
    for (int i = 0; i < 8; i++) begin
      if (k[i]) n[4*i+3 -: 4] = s[4*i+3 -: 4];
    end
    return n;
  endfunction

  function automatic logic [2:0] f_sts(input logic [9:0] s, input logic p, input logic o);
    if (s == 10'h017 || (!o && (s == 10'h000 || s == 10'h014 || s == 10'h015))) return 3'h5;
    if (!p && !(s == 10'h000 || s == 10'h001 || s == 10'h008 || s == 10'h009)) return 3'h3;
    return 3'h1;
  endfunction

  initial begin
    req = '0;
    aresetn = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    fp = 32'h0;
    cr = 32'h0;
    spn = '{10'h001, 10'h008, 10'h009, 10'h016, 10'h000, 10'h014, 10'h015, 10'h110, 10'h017};
    spa = '{msd_pkg::A_XER, msd_pkg::A_LR, msd_pkg::A_CTR, msd_pkg::A_DEC, msd_pkg::A_MQ,
            msd_pkg::A_CLOCK_UPPER_REGISTER, msd_pkg::A_CLOCK_LOWER_REGISTER, msd_pkg::A_LAST_SPR, msd_pkg::A_LAST_SPR};
    void'($urandom(71162));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(msd_pkg::A_FP_STATUS_CONTROL_REGISTER, 32'h0);
    rdc(msd_pkg::A_CR, 32'h0);
    rd(8'h38, d, r);
    chk({30'h0, r}, {30'h0, msd_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h3c, $urandom, r);
    chk({30'h0, r}, {30'h0, msd_pkg::RESP_SLVERR});
    for (int i = 0; i < 16; i++) begin
      bf = (i < 2) ? 3'h0 : 3'($urandom);
      imm = (i < 2) ? 4'hf : 4'($urandom);
      rc = (i == 0) ? 1'b1 : 1'($urandom);
      fp = f_fld(fp, bf, imm);
      if (rc) cr[27:24] = fp[31:28];
      exec({msd_pkg::OPC_FP, bf, 7'h0, imm, 1'b0, msd_pkg::XO_FLD_IMM, rc}, 3'h1);
      rdc(msd_pkg::A_FP_STATUS_CONTROL_REGISTER, fp);
      rdc(msd_pkg::A_CR, cr);
    end
    for (int i = 0; i < 4; i++) begin
      g = {msd_pkg::OPC_FP, 5'(1 + i[0]), 10'h0, msd_pkg::XO_BIT_SET, 1'b0};
      if (i[1]) g[10:1] = msd_pkg::XO_BIT_CLR;
      exec(g, 3'h1);
      rdc(msd_pkg::A_FP_STATUS_CONTROL_REGISTER, fp);
    end
    for (int i = 0; i < 12; i++) begin
      g = (i == 0) ? 32'h7542_ffee : $urandom;
      m = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($urandom);
      rs = 5'($urandom);
      wr(8'h80 + {rs, 2'h0}, g, r);
      cr = f_crm(cr, g, m);
      exec({msd_pkg::OPC_FX, rs, 1'b0, m, 1'b0, msd_pkg::XO_CR_FLD, 1'b0}, 3'h1);
      rdc(msd_pkg::A_CR, cr);
    end
    for (int c = 0; c < 4; c++) begin
      wr(msd_pkg::A_CTRL, {30'h0, 2'(c)}, r);
      for (int k = 0; k < 9; k++) begin
        g = $urandom;
        rs = 5'($urandom);
        wr(8'h80 + {rs, 2'h0}, g, r);
        rd(spa[k], pre, r);
        d = {msd_pkg::OPC_FX, rs, spn[k][4:0], spn[k][9:5], msd_pkg::XO_SPR, 1'b0};
        exec(d, f_sts(spn[k], c[0], c[1]));
        if (f_sts(spn[k], c[0], c[1]) == 3'h1) pre = (k > 6) ? 32'(spn[k]) : g;
        rdc(spa[k], pre);
      end
    end
    rdc(msd_pkg::A_CR, cr);
    wr(msd_pkg::A_IRQ_STS, 32'h7, r);
    wr(msd_pkg::A_INSTR, 32'h0, r);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(msd_pkg::A_IRQ_MASK, 32'h4, r);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rdc(msd_pkg::A_IRQ_STS, 32'h5);
    wr(msd_pkg::A_IRQ_STS, 32'h4, r);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rdc(msd_pkg::A_IRQ_STS, 32'h1);
    results();
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
